// *** inc/ips_pkg.sv ***
// Shared constants and types for the indexed positioning sequencer
package ips_pkg;

  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned STEPS_PER_REV   = 4096;
  localparam int unsigned TGT_N           = 5;
  localparam int unsigned MSG_TIMEOUT_MS  = 16;
  localparam int unsigned MSG_TIMEOUT_CYC = CLK_HZ / 1000 * MSG_TIMEOUT_MS;
  localparam int unsigned BAUD_PC_BPS     = 19200;
  localparam int unsigned BAUD_PC_DIV     = CLK_HZ / BAUD_PC_BPS;
  localparam int unsigned SCAN_DWELL_US   = 10;
  localparam int unsigned SCAN_DWELL_CYC  = CLK_HZ / 1_000_000 * SCAN_DWELL_US;

  localparam logic [3:0]  BAUD_CODE_PC    = 4'h6;

  // Digital input positions: input n sits at bit n-1
  localparam int unsigned DIN_MOVE        = 0;
  localparam int unsigned DIN_HOME        = 1;
  localparam int unsigned DIN_PROX        = 2;
  localparam int unsigned DIN_CODE_LO     = 3;

  // Register byte addresses
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_KEYS       = 8'h04;
  localparam logic [7:0]  ADDR_STATUS     = 8'h08;
  localparam logic [7:0]  ADDR_HOME_SPD   = 8'h0C;
  localparam logic [7:0]  ADDR_JOG_SPD    = 8'h10;
  localparam logic [7:0]  ADDR_ZERO_WIN   = 8'h14;
  localparam logic [7:0]  ADDR_SCRATCH    = 8'h18;
  localparam logic [7:0]  ADDR_PRESEL     = 8'h1C;
  localparam logic [7:0]  ADDR_SERIAL     = 8'h20;
  localparam logic [7:0]  ADDR_DIO        = 8'h24;
  localparam logic [7:0]  ADDR_AXIS       = 8'h28;
  localparam logic [7:0]  ADDR_TGT1       = 8'h40;
  localparam logic [7:0]  ADDR_TGT5       = 8'h50;

  // Keypad key bits in the key register
  localparam int unsigned KEY_HOMING      = 0;
  localparam int unsigned KEY_TEACH_SEL   = 1;
  localparam int unsigned KEY_AUTO        = 2;
  localparam int unsigned KEY_EDIT        = 3;
  localparam int unsigned KEY_PLUS        = 4;
  localparam int unsigned KEY_MINUS       = 5;
  localparam int unsigned KEY_CONFIRM     = 6;
  localparam int unsigned KEY_STORE       = 7;

  // Serial config field positions
  localparam int unsigned SER_NODE_LO     = 4;
  localparam int unsigned SER_ENABLE      = 9;
  localparam int unsigned SER_INIT        = 10;

  localparam logic [15:0] HOME_SPD_RST    = 16'h0005;
  localparam logic [15:0] JOG_SPD_RST     = 16'h000A;
  localparam logic [15:0] ZERO_WIN_RST    = 16'h0000;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_HOMING = 5'b00010,
    ST_READY  = 5'b00100,
    ST_POS    = 5'b01000,
    ST_JOG    = 5'b10000
  } ips_state_e;

  typedef enum logic [2:0] {
    MD_AUTO  = 3'b001,
    MD_TEACH = 3'b010,
    MD_EDIT  = 3'b100
  } ips_mode_e;

endpackage

// *** core/ips_edge_det.sv ***
// Two-stage synchroniser with rising-edge detector
`timescale 1ns/1ps
`default_nettype none
module ips_edge_det #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q   <= '0;
      s2_q   <= '0;
      prev_q <= '0;
    end else begin
      s1_q   <= raw;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  assign lvl  = s2_q;
  assign rise = s2_q & ~prev_q;
endmodule
`default_nettype wire

// *** core/ips_bcd_scan.sv ***
// Four-digit BCD thumbwheel scanner, least significant digit first
`timescale 1ns/1ps
`default_nettype none
module ips_bcd_scan
  import ips_pkg::*;
#(
  parameter int unsigned DWELL = SCAN_DWELL_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  bcd_in,
  output logic      [3:0]  sel_q,
  output logic      [13:0] value_q,
  output logic             valid_q
);
  logic [15:0] div_q;
  logic [13:0] acc_q;
  logic [9:0]  wt_q;
  logic        tick;
  logic [13:0] part;

  // Digit sampled at the end of its dwell so the wheel contacts have settled
  assign tick = (div_q == 16'(DWELL - 1));
  // Widened before the product: four times a thousand does not fit in ten bits
  assign part = 14'(bcd_in) * 14'(wt_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q   <= 4'h1;
      acc_q   <= '0;
      wt_q    <= 10'h001;
      value_q <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      if (tick) begin
        if (sel_q[3]) begin
          value_q <= acc_q + part;
          valid_q <= 1'b1;
          acc_q   <= '0;
          wt_q    <= 10'h001;
          sel_q   <= 4'h1;
        end else begin
          acc_q   <= acc_q + part;
          wt_q    <= 10'(wt_q * 10'd10);
          sel_q   <= {sel_q[2:0], 1'b0};
        end
      end
    end
  end

  a_scan_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot(sel_q)) else $error("thumbwheel select not one-hot");
endmodule
`default_nettype wire

// *** core/ips_sequencer.sv ***
// Indexed positioning sequencer with APB register access
// Operation
// - Stay idle after power-up; no positioning until homing done.
// - Input 2 pulse or homing key starts homing.
// - Homing runs at homing speed until proximity input 3; that is zero.
// - Inputs 6..4 code 1..5 pick targets one to five; else zero.
// - Input 1 pulse launches trapezoidal move to selected target.
// - Targets are steps from homed zero, 4096 steps per revolution.
// - Status outputs high throughout homing, positioning and jogging.
// - Teach mode: plus/minus keys start or stop jog at jog speed.
// - Teach select key cycles dimension; confirm key captures axis position.
// - Edit mode: plus/minus change value, edit key advances dimension.
// - One key selects automatic mode, another commits targets to storage.
// - Scanner drives four selects LSD first, reads BCD digit per select.
// - Thumbwheel digits combine to decimal into the preselector target.
// - Speed reference inside window around zero forces commanded speed zero.
// - Host reads inputs and writes outputs directly, replacing internal program.
// - Baud code 6 gives 19200 bit/s and 16 ms message timeout.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ips_sequencer
  import ips_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = MSG_TIMEOUT_CYC,
  parameter int unsigned SCAN_CYC    = SCAN_DWELL_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  din,
  input  wire logic [31:0] axis_pos,
  input  wire logic        move_done,
  input  wire logic [15:0] speed_ref,
  input  wire logic        msg_start,
  input  wire logic        msg_end,
  input  wire logic [3:0]  bcd_in,
  output logic             homing_active,
  output logic             positioning_active,
  output logic             jogging_active,
  output logic [15:0]      speed_cmd,
  output logic             move_start,
  output logic [31:0]      move_target,
  output logic             zero_set,
  output logic             nv_store,
  output logic [15:0]      speed_out,
  output logic [3:0]       digit_sel,
  output logic [3:0]       gp_out,
  output logic             baud_tick,
  output logic             msg_timeout
);
  ips_state_e  st_q, st_d;
  ips_mode_e   mode_q;
  logic [31:0] tgt_q [1:TGT_N];
  logic [2:0]  dim_q;
  logic        homed_q, jog_neg_q, host_ctrl_q;
  logic [7:0]  key_q;
  logic [15:0] home_spd_q, jog_spd_q, win_q, scratch_q;
  logic [13:0] presel_q;
  logic [3:0]  baud_code_q;
  logic [4:0]  node_q;
  logic        ser_en_q, ser_ready_q;
  logic [31:0] rd_d;
  logic        acc, wr_en, hit, is_tgt;
  logic [2:0]  tix, code, pos_sel;
  logic [31:0] sel_target;
  logic [2:0]  d_lvl, d_rise;
  logic        home_cmd, move_cmd;
  logic [15:0] abs_ref;
  logic [3:0]  scan_sel;
  logic [13:0] scan_val;
  logic        scan_vld;
  logic [15:0] baud_cnt_q;
  logic [31:0] to_cnt_q;
  logic        msg_busy_q;

  ips_edge_det #(.W(3)) u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (din[DIN_PROX:DIN_MOVE]),
    .lvl     (d_lvl),
    .rise    (d_rise)
  );

  ips_bcd_scan #(.DWELL(SCAN_CYC)) u_scan (
    .pclk    (pclk),
    .presetn (presetn),
    .bcd_in  (bcd_in),
    .sel_q   (scan_sel),
    .value_q (scan_val),
    .valid_q (scan_vld)
  );

  // APB: one wait state, writes land on the edge that samples pready high
  assign acc    = psel & penable & ~pready;
  assign wr_en  = psel & penable & pready & pwrite;
  assign is_tgt = (paddr >= ADDR_TGT1) && (paddr <= ADDR_TGT5) && (paddr[1:0] == 2'b00);
  assign tix    = 3'(((paddr - ADDR_TGT1) >> 2) + 8'h01);

  always_comb begin
    hit  = 1'b1;
    rd_d = '0;
    case (paddr)
      ADDR_CTRL:     rd_d = {31'h0, host_ctrl_q};
      ADDR_KEYS:     rd_d = '0;
      ADDR_STATUS:   rd_d = {16'h0, jog_neg_q, homed_q, pos_sel, dim_q, mode_q, st_q};
      ADDR_HOME_SPD: rd_d = {16'h0, home_spd_q};
      ADDR_JOG_SPD:  rd_d = {16'h0, jog_spd_q};
      ADDR_ZERO_WIN: rd_d = {16'h0, win_q};
      ADDR_SCRATCH:  rd_d = {16'h0, scratch_q};
      ADDR_PRESEL:   rd_d = {18'h0, presel_q};
      ADDR_SERIAL:   rd_d = {21'h0, ser_ready_q, ser_en_q, node_q, baud_code_q};
      ADDR_DIO:      rd_d = {20'h0, gp_out, din};
      ADDR_AXIS:     rd_d = axis_pos;
      default: begin
        if (is_tgt) begin
          rd_d = tgt_q[tix];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc;
      prdata  <= (acc && !pwrite) ? rd_d : 32'h0;
      pslverr <= acc & ~hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_ctrl_q <= 1'b0;
      home_spd_q  <= HOME_SPD_RST;
      jog_spd_q   <= JOG_SPD_RST;
      win_q       <= ZERO_WIN_RST;
      gp_out      <= '0;
      key_q       <= '0;
    end else begin
      key_q <= (wr_en && paddr == ADDR_KEYS) ? pwdata[7:0] : 8'h00;
      if (wr_en) begin
        case (paddr)
          ADDR_CTRL:     host_ctrl_q <= pwdata[0];
          ADDR_HOME_SPD: home_spd_q  <= pwdata[15:0];
          ADDR_JOG_SPD:  jog_spd_q   <= pwdata[15:0];
          ADDR_ZERO_WIN: win_q       <= pwdata[15:0];
          ADDR_DIO:      gp_out      <= pwdata[11:8];
          default: ;
        endcase
      end
    end
  end

  // Host control masks the pin commands so a serial master owns the axis
  assign home_cmd = (d_rise[DIN_HOME] & ~host_ctrl_q) | key_q[KEY_HOMING];
  assign move_cmd = d_rise[DIN_MOVE] & ~host_ctrl_q;
  assign code     = din[DIN_CODE_LO+2:DIN_CODE_LO];
  assign pos_sel  = (code >= 3'd1 && code <= 3'd5) ? code : 3'd0;
  assign sel_target = (pos_sel == 3'd0) ? 32'h0 : tgt_q[pos_sel];

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:   if (home_cmd) st_d = ST_HOMING;
      ST_HOMING: if (d_lvl[DIN_PROX]) st_d = ST_READY;
      ST_READY: begin
        if (home_cmd) begin
          st_d = ST_HOMING;
        end else if (move_cmd && mode_q == MD_AUTO) begin
          st_d = ST_POS;
        end else if (mode_q == MD_TEACH && (key_q[KEY_PLUS] || key_q[KEY_MINUS])) begin
          st_d = ST_JOG;
        end
      end
      ST_POS:    if (move_done) st_d = ST_READY;
      ST_JOG:    if (key_q[KEY_PLUS] || key_q[KEY_MINUS]) st_d = ST_READY;
      default:   st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q               <= ST_IDLE;
      homed_q            <= 1'b0;
      homing_active      <= 1'b0;
      positioning_active <= 1'b0;
      jogging_active     <= 1'b0;
      zero_set           <= 1'b0;
      move_start         <= 1'b0;
      move_target        <= '0;
      jog_neg_q          <= 1'b0;
    end else begin
      st_q               <= st_d;
      homing_active      <= (st_d == ST_HOMING);
      positioning_active <= (st_d == ST_POS);
      jogging_active     <= (st_d == ST_JOG);
      zero_set           <= (st_q == ST_HOMING) && (st_d == ST_READY);
      if (st_q == ST_HOMING && st_d == ST_READY) begin
        homed_q <= 1'b1;
      end
      move_start <= (st_q == ST_READY) && (st_d == ST_POS);
      if (st_q == ST_READY && st_d == ST_POS) begin
        move_target <= sel_target;
      end
      if (st_q == ST_READY && st_d == ST_JOG) begin
        jog_neg_q <= key_q[KEY_MINUS];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_cmd <= '0;
    end else begin
      case (st_q)
        ST_HOMING: speed_cmd <= home_spd_q;
        ST_JOG:    speed_cmd <= jog_neg_q ? 16'(-jog_spd_q) : jog_spd_q;
        default:   speed_cmd <= '0;
      endcase
    end
  end

  // Mode keys are ignored mid-jog so a running jog cannot lose its stop key
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q   <= MD_AUTO;
      dim_q    <= 3'd1;
      nv_store <= 1'b0;
    end else begin
      nv_store <= key_q[KEY_STORE];
      if (st_q != ST_JOG) begin
        if (key_q[KEY_AUTO]) begin
          mode_q <= MD_AUTO;
        end else if (key_q[KEY_TEACH_SEL]) begin
          if (mode_q != MD_TEACH) begin
            mode_q <= MD_TEACH;
          end else begin
            dim_q <= (dim_q == 3'd5) ? 3'd1 : dim_q + 3'd1;
          end
        end else if (key_q[KEY_EDIT]) begin
          if (mode_q != MD_EDIT) begin
            mode_q <= MD_EDIT;
          end else begin
            dim_q <= (dim_q == 3'd5) ? 3'd1 : dim_q + 3'd1;
          end
        end
      end
    end
  end

  // Bus writes win over keypad edits landing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 1; i <= TGT_N; i++) begin
        tgt_q[i] <= '0;
      end
    end else begin
      if (wr_en && is_tgt) begin
        tgt_q[tix] <= pwdata;
      end else if (mode_q == MD_TEACH && st_q == ST_READY && key_q[KEY_CONFIRM]) begin
        tgt_q[dim_q] <= axis_pos;
      end else if (mode_q == MD_EDIT && key_q[KEY_PLUS]) begin
        tgt_q[dim_q] <= tgt_q[dim_q] + 32'h1;
      end else if (mode_q == MD_EDIT && key_q[KEY_MINUS]) begin
        tgt_q[dim_q] <= tgt_q[dim_q] - 32'h1;
      end
    end
  end

  assign abs_ref = speed_ref[15] ? 16'(-speed_ref) : speed_ref;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_q <= '0;
      speed_out <= '0;
      presel_q  <= '0;
      digit_sel <= '0;
    end else begin
      scratch_q <= abs_ref;
      speed_out <= (abs_ref <= win_q) ? 16'h0000 : speed_ref;
      digit_sel <= scan_sel;
      if (scan_vld) begin
        presel_q <= scan_val;
      end
    end
  end

  // Serial config: the port only comes up after the init bit is written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_code_q <= '0;
      node_q      <= '0;
      ser_en_q    <= 1'b0;
      ser_ready_q <= 1'b0;
    end else if (wr_en && paddr == ADDR_SERIAL) begin
      baud_code_q <= pwdata[3:0];
      node_q      <= pwdata[SER_NODE_LO+4:SER_NODE_LO];
      ser_en_q    <= pwdata[SER_ENABLE];
      if (!pwdata[SER_ENABLE]) begin
        ser_ready_q <= 1'b0;
      end else if (pwdata[SER_INIT] && ser_en_q) begin
        ser_ready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_q  <= '0;
      baud_tick   <= 1'b0;
      to_cnt_q    <= '0;
      msg_busy_q  <= 1'b0;
      msg_timeout <= 1'b0;
    end else begin
      baud_tick   <= 1'b0;
      msg_timeout <= 1'b0;
      if (ser_ready_q && baud_code_q == BAUD_CODE_PC) begin
        baud_cnt_q <= (baud_cnt_q == 16'(BAUD_PC_DIV - 1)) ? 16'h0000 : baud_cnt_q + 16'h0001;
        baud_tick  <= (baud_cnt_q == 16'(BAUD_PC_DIV - 1));
      end else begin
        baud_cnt_q <= '0;
      end
      if (msg_start && ser_ready_q) begin
        msg_busy_q <= 1'b1;
        to_cnt_q   <= '0;
      end else if (msg_end) begin
        msg_busy_q <= 1'b0;
      end else if (msg_busy_q) begin
        to_cnt_q <= to_cnt_q + 32'h1;
        if (to_cnt_q == 32'(TIMEOUT_CYC - 1)) begin
          msg_busy_q  <= 1'b0;
          msg_timeout <= 1'b1;
        end
      end
    end
  end

  a_no_move_unhomed: assert property (@(posedge pclk) disable iff (!presetn)
    !homed_q |-> !positioning_active && !move_start) else $error("move before homing");
  a_home_start: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_IDLE && home_cmd) |=> homing_active && st_q == ST_HOMING)
    else $error("homing not started");
  a_zero_on_prox: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_HOMING && d_lvl[DIN_PROX]) |=> zero_set && homed_q && !homing_active)
    else $error("zero not taken at sensor");
  a_move_target: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_READY && move_cmd && mode_q == MD_AUTO && !home_cmd)
    |=> move_start && move_target == $past(sel_target) ##1 !move_start)
    else $error("wrong move launch");
  a_zero_code: assert property (@(posedge pclk) disable iff (!presetn)
    (code == 3'd0 || code > 3'd5) |-> sel_target == 32'h0) else $error("bad position code");
  a_status_match: assert property (@(posedge pclk) disable iff (!presetn)
    homing_active == (st_q == ST_HOMING) && jogging_active == (st_q == ST_JOG)
    && positioning_active == (st_q == ST_POS)) else $error("status output mismatch");
  // Speed is built from the values that stood one cycle earlier
  a_jog_speed: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_JOG) |=> speed_cmd == ($past(jog_neg_q) ?
    16'(-$past(jog_spd_q)) : $past(jog_spd_q))) else $error("jog speed wrong");
  a_teach_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_q == MD_TEACH && st_q == ST_READY && key_q[KEY_CONFIRM] && !(wr_en && is_tgt))
    |=> tgt_q[$past(dim_q)] == $past(axis_pos)) else $error("teach capture lost");
  a_deadband: assert property (@(posedge pclk) disable iff (!presetn)
    (abs_ref <= win_q) |=> speed_out == 16'h0000) else $error("deadband not applied");
endmodule
`default_nettype wire

// *** testbench/ips_machine.sv ***
// Machine-side model: proximity sensor, move completion and thumbwheel
`timescale 1ns/1ps
`default_nettype none
module ips_machine (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       homing_active,
  input  wire logic       positioning_active,
  input  wire logic [3:0] digit_sel,
  output logic            prox,
  output logic            move_done,
  output logic [3:0]      bcd_in
);
  logic [7:0] run_q;

  // Counts how long the axis has travelled in the current activity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 8'h00;
    end else if (homing_active || positioning_active) begin
      run_q <= run_q + 8'h01;
    end else begin
      run_q <= 8'h00;
    end
  end

  // Sensor trips after a short run; it clears once homing stops the axis on it
  assign prox      = homing_active && (run_q >= 8'h14);
  assign move_done = positioning_active && (run_q >= 8'h0A);

  // Wheel reads 4321; with no select the pull-ups give all ones
  always_comb begin
    case (digit_sel)
      4'h1: bcd_in = 4'h1;
      4'h2: bcd_in = 4'h2;
      4'h4: bcd_in = 4'h3;
      4'h8: bcd_in = 4'h4;
      default: bcd_in = 4'hF;
    endcase
  end
endmodule
`default_nettype wire

// *** testbench/ips_sequencer_bench.sv ***
// Self-checking bench for the positioning sequencer
`timescale 1ns/1ps
`default_nettype none
module ips_sequencer_bench;
  import ips_pkg::*;
  localparam int unsigned TMO = 50;
  localparam int unsigned SCN = 4;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, axis_pos = 32'h0, rd;
  logic mv = 1'b0, hm = 1'b0, msg_start = 1'b0, msg_end = 1'b0, er;
  logic [2:0] code = 3'h0;
  logic [15:0] speed_ref = 16'h0;
  wire logic [31:0] prdata, move_target;
  wire logic pready, pslverr, prox, move_done, homing_active, positioning_active;
  wire logic jogging_active, move_start, zero_set, nv_store, baud_tick, msg_timeout;
  wire logic [15:0] speed_cmd, speed_out;
  wire logic [3:0] bcd_in, digit_sel, gp_out;
  wire logic [7:0] din;
  int n_errors = 0, checks_done = 0, n_starts = 0, n_zero = 0, n_store = 0, n_tmo = 0;

  assign din = {2'b00, code, prox, hm, mv};
  always #4 pclk = ~pclk;

  ips_sequencer #(.TIMEOUT_CYC(TMO), .SCAN_CYC(SCN)) i_ips_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .din(din), .axis_pos(axis_pos), .move_done(move_done), .speed_ref(speed_ref),
    .msg_start(msg_start), .msg_end(msg_end), .bcd_in(bcd_in),
    .homing_active(homing_active), .positioning_active(positioning_active),
    .jogging_active(jogging_active), .speed_cmd(speed_cmd), .move_start(move_start),
    .move_target(move_target), .zero_set(zero_set), .nv_store(nv_store),
    .speed_out(speed_out), .digit_sel(digit_sel), .gp_out(gp_out),
    .baud_tick(baud_tick), .msg_timeout(msg_timeout));

  ips_machine i_ips_machine (
    .pclk(pclk), .presetn(presetn), .homing_active(homing_active),
    .positioning_active(positioning_active), .digit_sel(digit_sel),
    .prox(prox), .move_done(move_done), .bcd_in(bcd_in));

  // Pulse outputs stand one cycle, so they are counted at every edge
  always @(posedge pclk) begin
    n_starts += (move_start === 1'b1);
    n_zero += (zero_set === 1'b1);
    n_store += (nv_store === 1'b1);
    n_tmo += (msg_timeout === 1'b1);
  end

  task give_verdict;
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask

  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) n_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task key(input int b);
    apb(1'b1, ADDR_KEYS, 32'h1 << b);
  endtask

  task pin(input bit h);
    @(posedge pclk);
    if (h) hm <= 1'b1;
    else mv <= 1'b1;
    repeat (2) @(posedge pclk);
    hm <= 1'b0;
    mv <= 1'b0;
  endtask

  task t_idle;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[4:0], 32'h01);
    apb(1'b0, ADDR_HOME_SPD, 32'h0);
    chk(rd, HOME_SPD_RST);
    pin(1'b0);
    cyc(6);
    chk(positioning_active, 32'h0);
    chk(n_starts, 32'h0);
  endtask

  task t_home;
    int k;
    apb(1'b1, ADDR_HOME_SPD, 32'h7);
    pin(1'b1);
    cyc(5);
    chk(homing_active, 32'h1);
    chk(speed_cmd, 32'h7);
    for (k = 0; k < 100 && homing_active !== 1'b0; k++) cyc(1);
    cyc(1);
    chk(n_zero, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[4:0], 32'h04);
    key(KEY_HOMING);
    cyc(3);
    chk(homing_active, 32'h1);
    for (k = 0; k < 100 && homing_active !== 1'b0; k++) cyc(1);
    cyc(1);
    chk(n_zero, 32'h2);
  endtask

  task t_pos;
    int c;
    int k;
    for (c = 1; c <= 5; c++) apb(1'b1, ADDR_TGT1 + 8'(4 * (c - 1)), 32'(c * 4097));
    for (c = 0; c < 8; c++) begin
      @(posedge pclk);
      code <= 3'(c);
      pin(1'b0);
      cyc(4);
      chk(positioning_active, 32'h1);
      chk(move_target, (c >= 1 && c <= 5) ? 32'(c * 4097) : 32'h0);
      pin(1'b0);
      for (k = 0; k < 100 && positioning_active !== 1'b0; k++) cyc(1);
      chk(n_starts, 32'(c + 1));
    end
  endtask

  task t_keys;
    key(KEY_TEACH_SEL);
    key(KEY_PLUS);
    cyc(3);
    chk(jogging_active, 32'h1);
    chk(speed_cmd, JOG_SPD_RST);
    key(KEY_PLUS);
    cyc(3);
    chk(jogging_active, 32'h0);
    key(KEY_MINUS);
    cyc(3);
    chk(speed_cmd, 32'hFFF6);
    key(KEY_MINUS);
    axis_pos <= 32'h3039;
    key(KEY_CONFIRM);
    apb(1'b0, ADDR_TGT1, 32'h0);
    chk(rd, 32'h3039);
    key(KEY_TEACH_SEL);
    key(KEY_CONFIRM);
    apb(1'b0, ADDR_TGT1 + 8'h04, 32'h0);
    chk(rd, 32'h3039);
    key(KEY_EDIT);
    key(KEY_MINUS);
    apb(1'b0, ADDR_TGT1 + 8'h04, 32'h0);
    chk(rd, 32'h3038);
    key(KEY_EDIT);
    key(KEY_PLUS);
    apb(1'b0, ADDR_TGT1 + 8'h08, 32'h0);
    chk(rd, 32'(3 * 4097 + 1));
    key(KEY_AUTO);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[7:5], 32'h1);
    key(KEY_STORE);
    cyc(3);
    chk(n_store, 32'h1);
  endtask

  task t_ser;
    int k;
    apb(1'b1, ADDR_SERIAL, 32'h206);
    apb(1'b1, ADDR_SERIAL, 32'h606);
    apb(1'b0, ADDR_SERIAL, 32'h0);
    chk(rd[10:0], 32'h606);
    for (k = 0; k < 7000 && baud_tick !== 1'b1; k++) cyc(1);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (baud_tick !== 1'b1 && k < 7000);
    chk(k, BAUD_PC_DIV);
    @(posedge pclk);
    msg_start <= 1'b1;
    @(posedge pclk);
    msg_start <= 1'b0;
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (msg_timeout !== 1'b1 && k < 200);
    chk(k >= TMO && k <= TMO + 2, 32'h1);
    @(posedge pclk);
    msg_start <= 1'b1;
    @(posedge pclk);
    msg_start <= 1'b0;
    repeat (5) @(posedge pclk);
    msg_end <= 1'b1;
    @(posedge pclk);
    msg_end <= 1'b0;
    cyc(100);
    chk(n_tmo, 32'h1);
  endtask

  task t_misc;
    logic [15:0] sv[4] = '{16'h000A, 16'h000B, 16'hFFF6, 16'hFFF5};
    logic [15:0] ev[4] = '{16'h0000, 16'h000B, 16'h0000, 16'hFFF5};
    int i;
    int k;
    apb(1'b1, ADDR_ZERO_WIN, 32'hA);
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      speed_ref <= sv[i];
      cyc(3);
      chk(speed_out, ev[i]);
    end
    apb(1'b0, ADDR_SCRATCH, 32'h0);
    chk(rd, 32'hB);
    apb(1'b0, ADDR_AXIS, 32'h0);
    chk(rd, 32'h3039);
    apb(1'b1, ADDR_CTRL, 32'h1);
    pin(1'b1);
    cyc(6);
    chk(homing_active, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b1, ADDR_DIO, 32'hA00);
    cyc(1);
    chk(gp_out, 32'hA);
    apb(1'b0, ADDR_DIO, 32'h0);
    chk(rd[7:0], 32'h38);
    apb(1'b0, 8'h30, 32'h0);
    chk(er, 32'h1);
    chk(rd, 32'h0);
    for (i = 0; i < 4; i++) begin
      for (k = 0; k < 100 && digit_sel !== 4'(1 << i); k++) cyc(1);
      chk(digit_sel, 32'(1 << i));
    end
    cyc(10);
    apb(1'b0, ADDR_PRESEL, 32'h0);
    chk(rd[13:0], 32'd4321);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_idle;
    t_home;
    t_pos;
    t_keys;
    t_ser;
    t_misc;
    give_verdict;
  end

  // Whole sequence needs about 14000 cycles
  initial begin
    #400000;
    n_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
